// [hdl/rtcs_pkg.sv]
// Purpose: Shared constants for the alarm and start-up control block
// Assumes: AHB-Lite word registers, byte address = 4 * index
// Notes:   Indices kept at their printed values
package rtcs_pkg;
    // ****************************************
    // Register indices
    // ****************************************
    localparam logic [19:0] IDX_PORT1_LATCH = 20'hfff01;
    localparam logic [19:0] IDX_PORT1_DIR   = 20'hfff21;
    localparam logic [19:0] IDX_ALARM_MIN   = 20'hfff9a;
    localparam logic [19:0] IDX_ALARM_HOUR  = 20'hfff9b;
    localparam logic [19:0] IDX_ALARM_WEEK  = 20'hfff9c;
    localparam logic [19:0] IDX_CTRL        = 20'hfff9d;
    localparam logic [19:0] IDX_STAT        = 20'hfff9e;
    localparam logic [19:0] IDX_TIME        = 20'hfff9f;
    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0]  RST_PORT1_LATCH = 8'h00;
    localparam logic [7:0]  RST_PORT1_DIR   = 8'hff;
    localparam logic [7:0]  RST_ALARM_MIN   = 8'h00;
    localparam logic [7:0]  RST_ALARM_HOUR  = 8'h12;
    localparam logic [7:0]  HOUR24_ZERO     = 8'h00;
    localparam logic [7:0]  RST_ALARM_WEEK  = 8'h00;
    localparam logic [7:0]  WEEK_MASK       = 8'h7f;
    localparam logic [7:0]  MIN_ALARM_MASK  = 8'h7f;
    localparam logic [7:0]  HOUR_ALARM_MASK = 8'h3f;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL_RUN      = 0;
    localparam int CTRL_WAIT     = 1;
    localparam int CTRL_ALARM_EN = 2;
    localparam int CTRL_FMT24    = 3;
    localparam int CTRL_SUPPLY   = 4;
    localparam int CTRL_FIXED_EN = 5;
    localparam int STAT_WAIT     = 0;
    localparam int STAT_ALARM    = 1;
    localparam int STAT_FIXED    = 2;
    localparam int PM_BIT        = 5;
    localparam int PIN_BIT       = 3;
    // ****************************************
    // BCD limits
    // ****************************************
    localparam logic [7:0]  BCD_59       = 8'h59;
    localparam logic [7:0]  BCD_23       = 8'h23;
    localparam logic [7:0]  BCD_12       = 8'h12;
    localparam logic [7:0]  BCD_11       = 8'h11;
    localparam logic [7:0]  BCD_32       = 8'h32;
    localparam logic [7:0]  BCD_31       = 8'h31;
    localparam logic [7:0]  BCD_21       = 8'h21;
    localparam logic [7:0]  BCD_01       = 8'h01;
    localparam logic [2:0]  LAST_DAY     = 3'h6;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_HZ         = 25000000;
    localparam int COUNT_CLOCK_HZ = 32768;
    localparam int COUNT_DIV      = CLK_HZ / COUNT_CLOCK_HZ;
    localparam int TICKS_PER_SEC  = 32768;
endpackage : rtcs_pkg

// [hdl/rtcs_count_tick.sv]
// Purpose: Count clock enable derived from the system clock
// Assumes: One system clock, synchronous reset
// Notes:   Tick is one system cycle wide
`timescale 1ns/10ps
module rtcs_count_tick #(
    parameter int DIV = rtcs_pkg::COUNT_DIV
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic standby_deep,
    output logic      tick
);
    import rtcs_pkg::*;

    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic        next_tick;

    always_comb
    begin
        next_cnt  = cnt;
        next_tick = 1'b0;
        if (standby_deep)
        begin
            next_cnt = cnt; // Count clock frozen in deepest standby [RULE_16]
        end
        else if (cnt == 16'(DIV - 1))
        begin
            next_cnt  = 16'h0000;
            next_tick = 1'b1;
        end
        else
        begin
            next_cnt = cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt  <= 16'h0000;
            tick <= 1'b0;
        end
        else
        begin
            cnt  <= next_cnt;
            tick <= next_tick;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    property p_standby_tick;
        @(posedge clk) disable iff (rst) standby_deep |=> !tick && $stable(cnt);
    endproperty
    a_standby_tick: assert property (p_standby_tick) else $error("tick in standby"); // [RULE_16]
endmodule : rtcs_count_tick

// [hdl/rtcs_alarm_ctrl.sv]
// Purpose: Alarm compare, time keeping and start-up handshake
// Assumes: AHB-Lite single word transfers, zero wait states
// Notes:   Wait status follows the request on count clock ticks
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/10ps
// Contract
// RULE_01: Alarm minute BCD 00-59, else no match
// RULE_02: Reset clears alarm minute and weekday mask
// RULE_03: Reset sets alarm hour to BCD 12
// RULE_04: Selecting 24-hour after reset reads hour zero
// RULE_05: Hour ranges per form, else no match
// RULE_06: 12-hour form: bit 5 means PM
// RULE_07: Midnight/noon are 12/32 or 00/12
// RULE_08: Seven-bit weekday mask, bit 7 zero
// RULE_09: Software clears port 1 bit 3 direction
// RULE_10: Software keeps port 1 bit 3 latch zero
// RULE_11: Enable clock domain after oscillation stable
// RULE_12: Correction registers only when correction needed
// RULE_13: Two count clocks after run before standby
// RULE_14: Wait request/status handshake before standby
// RULE_15: Precautions skipped after clock interrupt occurred
// RULE_16: Count clock stops in deepest standby
// RULE_17: Wait request freezes time counters
// RULE_18: Disable alarm match before changing alarm
// RULE_19: Shared interrupt, separate alarm/fixed flags
// RULE_20: Enabled match of minute, hour, day flags alarm
module rtcs_alarm_ctrl #(
    parameter int TICKS_PER_SEC = rtcs_pkg::TICKS_PER_SEC
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        standby_deep,
    output logic             clock_interrupt,
    output logic             one_hertz_output_pin,
    output logic             one_hertz_output_pin_oe
);
    import rtcs_pkg::*;
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] rtcs_bcd_inc(input logic [7:0] x);
        if (x[3:0] == 4'h9)
            return {x[7:4] + 4'h1, 4'h0};
        return x + 8'h01;
    endfunction : rtcs_bcd_inc
    function automatic logic rtcs_bcd_ok(input logic [7:0] x);
        return x[3:0] <= 4'h9;
    endfunction : rtcs_bcd_ok
    function automatic logic [7:0] rtcs_hour_inc(input logic [7:0] h, input logic fmt24);
        logic [7:0] v;
        v = {3'b000, h[4:0]};
        if (fmt24)
            return (h == BCD_23) ? HOUR24_ZERO : rtcs_bcd_inc(h);
        if (v == BCD_12)
            return {2'b00, h[PM_BIT], 5'h01};
        if (v == BCD_11)
            return h[PM_BIT] ? BCD_12 : BCD_32; // Midnight 12, noon 32 [RULE_07] [RULE_06]
        return rtcs_bcd_inc(v) | {2'b00, h[PM_BIT], 5'h00};
    endfunction : rtcs_hour_inc
    // ****************************************
    // State
    // ****************************************
    logic        count_tick;
    logic [7:0]  port1_output_latch;
    logic [7:0]  port1_direction;
    logic [7:0]  alarm_minute;
    logic [7:0]  alarm_hour;
    logic [7:0]  alarm_weekday_mask;
    logic [5:0]  ctrl;
    logic        counter_wait_status;
    logic        alarm_detected_flag;
    logic        fixed_cycle_flag;
    logic        hour_written;
    logic [7:0]  cur_sec;
    logic [7:0]  cur_min;
    logic [7:0]  cur_hour;
    logic [2:0]  cur_week;
    logic [15:0] sub_cnt;
    logic        minute_edge;
    logic        wr_pend;
    logic [19:0] wr_idx;
    logic [7:0]  next_port1_output_latch;
    logic [7:0]  next_port1_direction;
    logic [7:0]  next_alarm_minute;
    logic [7:0]  next_alarm_hour;
    logic [7:0]  next_alarm_weekday_mask;
    logic [5:0]  next_ctrl;
    logic        next_counter_wait_status;
    logic        next_alarm_detected_flag;
    logic        next_fixed_cycle_flag;
    logic        next_hour_written;
    logic [7:0]  next_cur_sec;
    logic [7:0]  next_cur_min;
    logic [7:0]  next_cur_hour;
    logic [2:0]  next_cur_week;
    logic [15:0] next_sub_cnt;
    logic        next_minute_edge;
    logic        next_wr_pend;
    logic [19:0] next_wr_idx;
    logic [31:0] next_hrdata;
    logic        next_clock_interrupt;
    logic        next_pin;
    logic        next_pin_oe;
    logic        addr_phase;
    logic [19:0] a_idx;
    logic [31:0] rd_mux;
    logic        time_wr;
    logic        running;
    logic        sec_tick;
    logic        min_ok;
    logic        hour_ok;
    logic        alarm_hit;
    rtcs_count_tick #(
        .DIV          (COUNT_DIV)
    ) u_tick (
        .clk          (clk),
        .rst          (rst),
        .standby_deep (standby_deep), // [RULE_16]
        .tick         (count_tick)
    );
    // ****************************************
    // Bus decode and read mux
    // ****************************************
    assign addr_phase = hsel && hready && htrans[1];
    assign a_idx      = haddr[21:2];
    assign time_wr    = wr_pend && (wr_idx == IDX_TIME) && counter_wait_status;
    always_comb
    begin
        case (a_idx)
            IDX_PORT1_LATCH: rd_mux = {24'h000000, port1_output_latch};
            IDX_PORT1_DIR:   rd_mux = {24'h000000, port1_direction};
            IDX_ALARM_MIN:   rd_mux = {24'h000000, alarm_minute};
            IDX_ALARM_HOUR:  rd_mux = {24'h000000, alarm_hour};
            IDX_ALARM_WEEK:  rd_mux = {24'h000000, alarm_weekday_mask};
            IDX_CTRL:        rd_mux = {26'h0000000, ctrl};
            IDX_STAT:        rd_mux = {29'h00000000, fixed_cycle_flag, alarm_detected_flag, counter_wait_status};
            IDX_TIME:        rd_mux = {5'h00, cur_week, cur_hour, cur_min, cur_sec};
            default:         rd_mux = 32'h00000000;
        endcase
    end
    // ****************************************
    // Alarm compare
    // ****************************************
    assign min_ok  = rtcs_bcd_ok(alarm_minute) && (alarm_minute <= BCD_59); // [RULE_01]
    assign hour_ok = rtcs_bcd_ok(alarm_hour) && (ctrl[CTRL_FMT24] ? (alarm_hour <= BCD_23) :
                     ((alarm_hour >= BCD_01 && alarm_hour <= BCD_12) ||
                      (alarm_hour >= BCD_21 && alarm_hour <= BCD_32))); // [RULE_05]
    assign alarm_hit = minute_edge && ctrl[CTRL_ALARM_EN] && min_ok && hour_ok &&
                       (cur_min == alarm_minute) && (cur_hour == alarm_hour) &&
                       alarm_weekday_mask[cur_week]; // [RULE_20]
    // Counting needs both the domain enable and the run bit [RULE_11]
    assign running  = ctrl[CTRL_SUPPLY] && ctrl[CTRL_RUN];
    assign sec_tick = count_tick && running && !counter_wait_status && (sub_cnt == 16'(TICKS_PER_SEC - 1));
    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        next_port1_output_latch  = port1_output_latch;
        next_port1_direction     = port1_direction;
        next_alarm_minute        = alarm_minute;
        next_alarm_hour          = alarm_hour;
        next_alarm_weekday_mask  = alarm_weekday_mask;
        next_ctrl                = ctrl;
        next_counter_wait_status = counter_wait_status;
        next_alarm_detected_flag = alarm_detected_flag;
        next_fixed_cycle_flag    = fixed_cycle_flag;
        next_hour_written        = hour_written;
        next_cur_sec             = cur_sec;
        next_cur_min             = cur_min;
        next_cur_hour            = cur_hour;
        next_cur_week            = cur_week;
        next_sub_cnt             = sub_cnt;
        next_minute_edge         = 1'b0;
        next_wr_pend             = addr_phase && hwrite;
        next_wr_idx              = addr_phase ? a_idx : wr_idx;
        next_hrdata              = (addr_phase && !hwrite) ? rd_mux : hrdata;
        next_clock_interrupt     = 1'b0;
        // Pin shows the 1 Hz phase only when bit 3 is an output and latch is zero
        next_pin_oe              = !port1_direction[PIN_BIT];
        next_pin                 = !port1_output_latch[PIN_BIT] && (sub_cnt < 16'(TICKS_PER_SEC / 2)) && running;
        // Status follows the request on the count clock [RULE_14]
        if (count_tick)
            next_counter_wait_status = ctrl[CTRL_WAIT];
        // Counters frozen while waiting [RULE_17]
        if (count_tick && running && !counter_wait_status)
            next_sub_cnt = (sub_cnt == 16'(TICKS_PER_SEC - 1)) ? 16'h0000 : sub_cnt + 16'h0001;
        if (sec_tick)
        begin
            next_cur_sec = (cur_sec == BCD_59) ? 8'h00 : rtcs_bcd_inc(cur_sec);
            if (ctrl[CTRL_FIXED_EN])
                next_fixed_cycle_flag = 1'b1;
            if (cur_sec == BCD_59)
            begin
                next_minute_edge = 1'b1;
                next_cur_min     = (cur_min == BCD_59) ? 8'h00 : rtcs_bcd_inc(cur_min);
                if (cur_min == BCD_59)
                begin
                    next_cur_hour = rtcs_hour_inc(cur_hour, ctrl[CTRL_FMT24]);
                    if (next_cur_hour == (ctrl[CTRL_FMT24] ? HOUR24_ZERO : BCD_12))
                        next_cur_week = (cur_week == LAST_DAY) ? 3'h0 : cur_week + 3'h1;
                end
            end
        end
        if (alarm_hit)
            next_alarm_detected_flag = 1'b1;
        next_clock_interrupt = alarm_hit || (sec_tick && ctrl[CTRL_FIXED_EN]); // [RULE_19]
        // Write data phase
        if (wr_pend && hready)
        begin
            case (wr_idx)
                IDX_PORT1_LATCH: next_port1_output_latch = hwdata[7:0];
                IDX_PORT1_DIR:   next_port1_direction    = hwdata[7:0];
                IDX_ALARM_MIN:   next_alarm_minute       = hwdata[7:0] & MIN_ALARM_MASK;
                IDX_ALARM_HOUR:
                begin
                    next_alarm_hour   = hwdata[7:0] & HOUR_ALARM_MASK;
                    next_hour_written = 1'b1;
                end
                IDX_ALARM_WEEK:  next_alarm_weekday_mask = hwdata[7:0] & WEEK_MASK; // [RULE_08]
                IDX_CTRL:
                begin
                    next_ctrl = hwdata[5:0];
                    // Untouched default follows a switch to 24-hour form [RULE_04]
                    if (hwdata[CTRL_FMT24] && !ctrl[CTRL_FMT24] && !hour_written)
                        next_alarm_hour = HOUR24_ZERO;
                end
                IDX_STAT:
                begin
                    // Write zero clears; a same-cycle event keeps the flag
                    if (!hwdata[STAT_ALARM] && !alarm_hit)
                        next_alarm_detected_flag = 1'b0;
                    if (!hwdata[STAT_FIXED] && !(sec_tick && ctrl[CTRL_FIXED_EN]))
                        next_fixed_cycle_flag = 1'b0;
                end
                IDX_TIME:
                begin
                    // Time only written while frozen, so no tick can collide [RULE_17]
                    if (counter_wait_status)
                    begin
                        next_cur_sec  = hwdata[7:0];
                        next_cur_min  = hwdata[15:8];
                        next_cur_hour = hwdata[23:16];
                        next_cur_week = hwdata[26:24];
                    end
                end
                default:
                begin
                end
            endcase
        end
    end
    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            port1_output_latch      <= RST_PORT1_LATCH;
            port1_direction         <= RST_PORT1_DIR;
            alarm_minute            <= RST_ALARM_MIN;  // [RULE_02]
            alarm_hour              <= RST_ALARM_HOUR; // [RULE_03]
            alarm_weekday_mask      <= RST_ALARM_WEEK; // [RULE_02]
            ctrl                    <= 6'h00;
            counter_wait_status     <= 1'b0;
            alarm_detected_flag     <= 1'b0;
            fixed_cycle_flag        <= 1'b0;
            hour_written            <= 1'b0;
            cur_sec                 <= 8'h00;
            cur_min                 <= 8'h00;
            cur_hour                <= BCD_12;
            cur_week                <= 3'h0;
            sub_cnt                 <= 16'h0000;
            minute_edge             <= 1'b0;
            wr_pend                 <= 1'b0;
            wr_idx                  <= 20'h00000;
            hrdata                  <= 32'h00000000;
            hreadyout               <= 1'b1;
            hresp                   <= 1'b0;
            clock_interrupt         <= 1'b0;
            one_hertz_output_pin    <= 1'b0;
            one_hertz_output_pin_oe <= 1'b0;
        end
        else
        begin
            port1_output_latch      <= next_port1_output_latch;
            port1_direction         <= next_port1_direction;
            alarm_minute            <= next_alarm_minute;
            alarm_hour              <= next_alarm_hour;
            alarm_weekday_mask      <= next_alarm_weekday_mask;
            ctrl                    <= next_ctrl;
            counter_wait_status     <= next_counter_wait_status;
            alarm_detected_flag     <= next_alarm_detected_flag;
            fixed_cycle_flag        <= next_fixed_cycle_flag;
            hour_written            <= next_hour_written;
            cur_sec                 <= next_cur_sec;
            cur_min                 <= next_cur_min;
            cur_hour                <= next_cur_hour;
            cur_week                <= next_cur_week;
            sub_cnt                 <= next_sub_cnt;
            minute_edge             <= next_minute_edge;
            wr_pend                 <= next_wr_pend;
            wr_idx                  <= next_wr_idx;
            hrdata                  <= next_hrdata;
            hreadyout               <= 1'b1;
            hresp                   <= 1'b0;
            clock_interrupt         <= next_clock_interrupt;
            one_hertz_output_pin    <= next_pin;
            one_hertz_output_pin_oe <= next_pin_oe;
        end
    end
    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_min_range;
        alarm_hit |-> alarm_minute[7:4] <= 4'h5 && alarm_minute[3:0] <= 4'h9;
    endproperty
    a_min_range: assert property (p_min_range) else $error("alarm hit on bad minute"); // [RULE_01]
    property p_reset_clear;
        @(posedge clk) rst |=> alarm_minute == 8'h00 && alarm_weekday_mask == 8'h00;
    endproperty
    a_reset_clear: assert property (disable iff (1'b0) p_reset_clear) else $error("reset not cleared"); // [RULE_02]
    property p_reset_hour;
        @(posedge clk) rst |=> alarm_hour == 8'h12 && !hour_written;
    endproperty
    a_reset_hour: assert property (disable iff (1'b0) p_reset_hour) else $error("hour reset wrong"); // [RULE_03]
    property p_hour_range;
        alarm_hit |-> hour_ok && (ctrl[CTRL_FMT24] || alarm_hour != 8'h00);
    endproperty
    a_hour_range: assert property (p_hour_range) else $error("alarm hit on bad hour"); // [RULE_05]
    property p_week_bit7;
        alarm_weekday_mask[7] == 1'b0 ##1 alarm_weekday_mask[7] == 1'b0;
    endproperty
    a_week_bit7: assert property (p_week_bit7) else $error("weekday bit 7 set"); // [RULE_08]
    property p_wait_follow;
        count_tick |=> counter_wait_status == $past(ctrl[CTRL_WAIT]);
    endproperty
    a_wait_follow: assert property (p_wait_follow) else $error("wait status lag"); // [RULE_14]
    property p_wait_freeze;
        counter_wait_status && !time_wr |=> $stable(cur_sec) && $stable(cur_min) && $stable(sub_cnt);
    endproperty
    a_wait_freeze: assert property (p_wait_freeze) else $error("counter moved while waiting"); // [RULE_17]
    property p_hit_flag;
        alarm_hit |=> alarm_detected_flag && clock_interrupt;
    endproperty
    a_hit_flag: assert property (p_hit_flag) else $error("alarm not flagged"); // [RULE_20]
    property p_irq_cause;
        clock_interrupt |-> alarm_detected_flag || fixed_cycle_flag;
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt without flag"); // [RULE_19]
endmodule : rtcs_alarm_ctrl

// [tb/tb_top.sv]
// Purpose: Self-checking bench for the alarm and start-up control block
// Assumes: Zero-wait AHB-Lite slave, one second = 4 count ticks
// Notes:   Prints only mismatches and the verdict
`timescale 1ns/10ps
module tb_top;
    import rtcs_pkg::*;
    logic        clk;
    logic        rst;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        standby_deep;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        clock_interrupt;
    logic        pin_oe;
    logic        pin;
    int          mismatches;
    int          cmp_count;
    logic [31:0] rv;
    rtcs_alarm_ctrl #(.TICKS_PER_SEC(4)) i_dut (
        .clk(clk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .standby_deep(standby_deep), .clock_interrupt(clock_interrupt),
        .one_hertz_output_pin(pin), .one_hertz_output_pin_oe(pin_oe));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic stop_test();
        if (mismatches == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Master holds each phase until hready is seen high at an edge
    task automatic xfer(input logic [19:0] idx, input logic wr, input logic [31:0] d);
        htrans <= 2'b10;
        haddr  <= {10'h0, idx, 2'b00};
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rv = hrdata;
        chk({31'h0, hresp}, 32'h0);
    endtask : xfer
    task automatic rdchk(input logic [19:0] idx, input logic [31:0] exp);
        xfer(idx, 1'b0, 32'h0);
        chk(rv, exp);
    endtask : rdchk
    task automatic wrchk(input logic [19:0] idx, input logic [31:0] d, input logic [31:0] exp);
        xfer(idx, 1'b1, d);
        rdchk(idx, exp);
    endtask : wrchk
    // Bounded poll; the status follows the request within one count tick
    task automatic poll(input logic v);
        int n;
        n = 0;
        do
        begin
            xfer(IDX_STAT, 1'b0, 32'h0);
            n++;
        end
        while (rv[STAT_WAIT] !== v && n < 1000);
        chk({31'h0, rv[STAT_WAIT]}, {31'h0, v});
    endtask : poll
    // Waits for the interrupt pulse or until the span runs out
    task automatic wait_irq(input int span, output logic seen);
        int n;
        seen = 1'b0;
        for (n = 0; n < span && !seen; n++)
        begin
            @(posedge clk);
            seen = (clock_interrupt === 1'b1);
        end
    endtask : wait_irq
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        rdchk(IDX_PORT1_LATCH, {24'h0, RST_PORT1_LATCH});
        rdchk(IDX_PORT1_DIR, {24'h0, RST_PORT1_DIR});
        rdchk(IDX_ALARM_MIN, 32'h00);
        rdchk(IDX_ALARM_HOUR, 32'h12);
        rdchk(IDX_ALARM_WEEK, 32'h00);
        wrchk(20'hfffa0, 32'hffffffff, 32'h0);
        xfer(IDX_CTRL, 1'b1, 32'h08);
        rdchk(IDX_ALARM_HOUR, 32'h00);
        xfer(IDX_CTRL, 1'b1, 32'h00);
        wrchk(IDX_ALARM_MIN, 32'hff, 32'h7f);
        wrchk(IDX_ALARM_HOUR, 32'hff, 32'h3f);
        wrchk(IDX_ALARM_WEEK, 32'hff, 32'h7f);
        wrchk(IDX_PORT1_DIR, 32'hf7, 32'hf7);
        @(posedge clk);
        chk({31'h0, pin_oe}, 32'h1);
    endtask : t_regs
    // Alarm is disabled while edited, time set to one second before rollover
    task automatic t_alarm(input logic [7:0] amin, input logic [7:0] hr, input logic [7:0] mask, input logic hit);
        logic seen;
        xfer(IDX_CTRL, 1'b1, 32'h13);
        xfer(IDX_ALARM_MIN, 1'b1, {24'h0, amin});
        xfer(IDX_ALARM_HOUR, 1'b1, {24'h0, hr});
        xfer(IDX_ALARM_WEEK, 1'b1, {24'h0, mask});
        poll(1'b1);
        wrchk(IDX_TIME, {8'h00, hr, 16'h0059}, {8'h00, hr, 16'h0059});
        xfer(IDX_CTRL, 1'b1, 32'h15);
        poll(1'b0);
        wait_irq(5000, seen);
        chk({31'h0, seen}, {31'h0, hit});
        rdchk(IDX_STAT, {29'h0, 1'b0, hit, 1'b0});
        xfer(IDX_STAT, 1'b1, 32'h0);
        xfer(IDX_CTRL, 1'b1, 32'h00);
    endtask : t_alarm
    // Standby freezes the count clock; a second that needs 3048 cycles must not pass
    task automatic t_standby();
        logic seen;
        xfer(IDX_CTRL, 1'b1, 32'h31);
        repeat (2 * COUNT_DIV) @(posedge clk);
        standby_deep <= 1'b1;
        repeat (3) @(posedge clk);
        wait_irq(4000, seen);
        chk({31'h0, seen}, 32'h0);
        standby_deep <= 1'b0;
        wait_irq(5000, seen);
        chk({31'h0, seen}, 32'h1);
        @(posedge clk);
        chk({31'h0, pin}, 32'h1);
        standby_deep <= 1'b1;
        repeat (3) @(posedge clk);
        wait_irq(4000, seen);
        chk({31'h0, seen}, 32'h0);
        standby_deep <= 1'b0;
        rdchk(IDX_STAT, 32'h4);
        xfer(IDX_STAT, 1'b1, 32'h0);
        xfer(IDX_CTRL, 1'b1, 32'h00);
    endtask : t_standby
    initial
    begin
        #(40 * 60000);
        mismatches++;
        stop_test();
    end
    initial
    begin
        rst          = 1'b1;
        haddr        = 32'h0;
        htrans       = 2'b00;
        hwrite       = 1'b0;
        hwdata       = 32'h0;
        standby_deep = 1'b0;
        mismatches   = 0;
        cmp_count    = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_alarm(8'h01, 8'h12, 8'h01, 1'b1);
        t_alarm(8'h01, 8'h32, 8'h01, 1'b1);
        t_alarm(8'h01, 8'h12, 8'h40, 1'b0);
        t_alarm(8'h02, 8'h12, 8'h7f, 1'b0);
        t_standby();
        stop_test();
    end
endmodule : tb_top
